// File: src/fdcml_map.svh
// Purpose: Constants for the mode, lock and version command logic
// Assumes: 25 MHz core clock
// Notes: Opcodes are text macros of this header
`ifndef FDCML_MAP_SVH
`define FDCML_MAP_SVH
`define FDCML_OP_MODE 8'h01
`define FDCML_OP_LOCK 8'h14
`define FDCML_OP_LOCK_MASK 8'h7f
`define FDCML_OP_VERSION 8'h18
`define FDCML_INVALID_STATUS 8'h80
`define FDCML_LOCK_BIT 4
`define FDCML_STATUS_READY 7
`define FDCML_STATUS_DIR 6
`define FDCML_STATUS_BUSY 4
`define FDCML_THRESHOLD_RST 4'h0
`define FDCML_PRECOMP_RST 8'h00
`define FDCML_SETTLE_RST 4'h8
`define FDCML_DENS_RST 2'h3
`define FDCML_CLK_KHZ 25000
`define FDCML_LOWPWR_MS 512
`define FDCML_LOWPWR_CYC (`FDCML_LOWPWR_MS * `FDCML_CLK_KHZ)
`define FDCML_SETTLE_UNIT_US 2000
`define FDCML_SETTLE_UNIT_CYC (`FDCML_SETTLE_UNIT_US * `FDCML_CLK_KHZ / 1000)
`define FDCML_RECAL_STD 12'd85
`define FDCML_RECAL_STD_W 12'd3925
`define FDCML_RECAL_MAX 12'd255
`define FDCML_RECAL_MAX_W 12'd4095
`endif

// File: src/fdcml_pkg.sv
// Purpose: Types for the mode, lock and version command logic
// Assumes: Nothing
// Notes: Rate codes follow the data rate select field
package fdcml_pkg;
    typedef enum logic [1:0] {
        fdcml_rate_500 = 2'h0,
        fdcml_rate_300 = 2'h1,
        fdcml_rate_250 = 2'h2,
        fdcml_rate_1000 = 2'h3
    } fdcml_rate_e;
    typedef struct packed {
        logic fifo_enable;
        logic [3:0] fifo_threshold;
        logic [7:0] precomp_start_track;
        logic fifo_write_bypass;
        logic fifo_read_bypass;
        logic burst_disable;
    } fdcml_locked_s;
    typedef struct packed {
        logic motor_timer_select;
        logic index_field_omit;
        logic implied_seek_honour;
        logic [1:0] power_save_select;
        logic wide_track_select;
        logic recal_limit_select;
        logic [1:0] density_output;
        logic scan_wildcard_disable;
        logic [3:0] head_settle;
        logic gate_diagnostic;
        logic pump_diagnostic;
    } fdcml_mode_s;
endpackage

// File: src/fdcml_sync.sv
// Purpose: Three stage synchroniser for pin inputs
// Assumes: Input is asynchronous to clock
// Notes: Output changes once stages two and three agree
`timescale 1ns/1ns
module fdcml_sync (
    input wire logic clock,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    logic [2:0] stage;
    wire agree = stage[1] == stage[2];
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage <= 3'h0;
            level <= 1'b0;
        end else begin
            stage <= {stage[1:0], pin};
            if (agree)
                level <= stage[2];
        end
    end
endmodule

// File: src/fdcml_timer.sv
// Purpose: Down counter for low power and head settle delays
// Assumes: Load has priority over counting
// Notes: Done is a one cycle pulse at expiry
`timescale 1ns/1ns
module fdcml_timer #(
    parameter int WIDTH = 32
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    input wire logic cancel,
    output logic busy,
    output logic done
);
    logic [WIDTH-1:0] remain;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            remain <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= busy && !cancel && !load && remain == WIDTH'(1);
            if (load) begin
                remain <= count;
                busy <= count != '0;
            end else if (cancel) begin
                busy <= 1'b0;
            end else if (busy) begin
                remain <= remain - WIDTH'(1);
                busy <= remain != WIDTH'(1);
            end
        end
    end
endmodule

// File: src/fdcml_core.sv
// Purpose: Invalid opcode, lock, mode and version command handling
// Assumes: Host bytes arrive as one cycle strobes from the host port
// Notes: Mode parameters arrive as one packed byte group with a strobe
`timescale 1ns/1ns
`include "fdcml_map.svh"
module fdcml_core #(
    parameter logic [7:0] ID_BYTE = 8'h5a, // Arbitrary identity value
    parameter logic [3:0] REVISION = 4'h1,
    parameter int LOWPWR_CYC = `FDCML_LOWPWR_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic soft_reset,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic result_read,
    output logic [7:0] result_byte,
    output logic [7:0] main_status_register,
    output logic result_pending,
    output logic cmd_interrupt,
    input wire logic config_valid,
    input wire fdcml_pkg::fdcml_locked_s config_in,
    input wire logic mode_valid,
    input wire fdcml_pkg::fdcml_mode_s mode_in,
    output fdcml_pkg::fdcml_locked_s locked,
    output fdcml_pkg::fdcml_mode_s mode,
    output logic keep_settings,
    input wire fdcml_pkg::fdcml_rate_e rate,
    input wire logic drive_type_pin,
    input wire logic media_change_pin,
    input wire logic head_unloaded,
    input wire logic cmd_seek_bit,
    input wire logic global_seek_enable,
    input wire logic seek_done,
    input wire logic pump_n,
    input wire logic write_data,
    input wire logic [7:0] scan_host,
    input wire logic [7:0] scan_disk,
    input wire logic byte_moved,
    input wire logic fifo_request,
    output logic do_implied_seek,
    output logic settling,
    output logic low_power,
    output logic density_output,
    output logic read_gate,
    output logic media_changed,
    output logic encoded_write_output,
    output logic scan_match,
    output logic write_via_fifo,
    output logic read_via_fifo,
    output logic dma_request,
    output logic wide_track_select,
    output logic motor_timer_select,
    output logic index_field_omit,
    output logic [11:0] recal_limit
);
    localparam fdcml_pkg::fdcml_locked_s LOCKED_RST = '{1'b0, `FDCML_THRESHOLD_RST,
        `FDCML_PRECOMP_RST, 1'b0, 1'b0, 1'b0};
    localparam fdcml_pkg::fdcml_mode_s MODE_RST = '{1'b0, 1'b0, 1'b0, 2'h0, 1'b0,
        1'b0, `FDCML_DENS_RST, 1'b0, `FDCML_SETTLE_RST, 1'b0, 1'b0};
    localparam int SETTLE_W = 24;

    typedef enum logic [1:0] {fdcml_idle, fdcml_result_invalid, fdcml_result_lock,
        fdcml_result_version} fdcml_phase_e;
    fdcml_phase_e phase, next_phase;
    logic pending_lock;

    function automatic logic [SETTLE_W-1:0] settle_cycles(input logic [3:0] n,
            input fdcml_pkg::fdcml_rate_e r);
        logic [SETTLE_W-1:0] unit;
        unit = SETTLE_W'(`FDCML_SETTLE_UNIT_CYC);
        unique case (r)
            fdcml_pkg::fdcml_rate_250: settle_cycles = SETTLE_W'(n) * (unit << 2);
            fdcml_pkg::fdcml_rate_300: settle_cycles = SETTLE_W'(n) * SETTLE_W'(
                (`FDCML_SETTLE_UNIT_CYC * 10) / 3);
            fdcml_pkg::fdcml_rate_500: settle_cycles = SETTLE_W'(n) * (unit << 1);
            fdcml_pkg::fdcml_rate_1000: settle_cycles = SETTLE_W'(n) * unit;
        endcase
    endfunction

    // Command decode
    wire is_lock = (cmd_byte & `FDCML_OP_LOCK_MASK) == `FDCML_OP_LOCK;
    wire is_version = cmd_byte == `FDCML_OP_VERSION;
    wire is_mode = cmd_byte == `FDCML_OP_MODE;
    wire take_cmd = cmd_valid && phase == fdcml_idle;
    wire lock_value = cmd_byte[7];
    wire lock_applies = phase == fdcml_result_lock && result_read;

    always_comb begin
        next_phase = phase;
        if (take_cmd) begin
            if (is_lock)
                next_phase = fdcml_result_lock;
            else if (is_version)
                next_phase = fdcml_result_version;
            else if (!is_mode)
                next_phase = fdcml_result_invalid;
        end else if (result_read && phase != fdcml_idle) begin
            next_phase = fdcml_idle;
        end
    end

    // Soft reset also cancels a lock awaiting its result read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase <= fdcml_idle;
            pending_lock <= 1'b0;
        end else if (soft_reset) begin
            phase <= fdcml_idle;
            pending_lock <= 1'b0;
        end else begin
            phase <= next_phase;
            if (take_cmd && is_lock)
                pending_lock <= lock_value;
        end
    end

    // Host answers; no interrupt for invalid or immediate results
    assign result_pending = phase != fdcml_idle;
    assign cmd_interrupt = 1'b0;
    assign main_status_register = {1'b1, result_pending, 1'b0, result_pending, 4'h0};
    always_comb begin
        unique case (phase)
            fdcml_idle: result_byte = 8'h00;
            fdcml_result_invalid: result_byte = `FDCML_INVALID_STATUS;
            fdcml_result_lock: result_byte = 8'(pending_lock) << `FDCML_LOCK_BIT;
            fdcml_result_version: result_byte = {ID_BYTE[7:4], REVISION};
        endcase
    end

    // Settings storage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            keep_settings <= 1'b0;
            locked <= LOCKED_RST;
            mode <= MODE_RST;
        end else if (soft_reset) begin
            if (!keep_settings)
                locked <= LOCKED_RST;
            else begin
                locked.fifo_enable <= locked.fifo_enable;
            end
            mode <= MODE_RST;
        end else begin
            if (lock_applies)
                keep_settings <= pending_lock;
            if (config_valid) begin
                locked.fifo_enable <= config_in.fifo_enable;
                locked.fifo_threshold <= config_in.fifo_threshold;
                locked.precomp_start_track <= config_in.precomp_start_track;
            end
            if (mode_valid) begin
                locked.fifo_write_bypass <= config_in.fifo_write_bypass;
                locked.fifo_read_bypass <= config_in.fifo_read_bypass;
                locked.burst_disable <= config_in.burst_disable;
                mode <= mode_in;
            end
        end
    end

    // Mode field decoding
    assign motor_timer_select = mode.motor_timer_select;
    assign index_field_omit = mode.index_field_omit;
    assign wide_track_select = mode.wide_track_select;
    assign do_implied_seek = global_seek_enable ||
        (mode.implied_seek_honour && cmd_seek_bit);
    assign recal_limit = mode.recal_limit_select ?
        (mode.wide_track_select ? `FDCML_RECAL_MAX_W : `FDCML_RECAL_MAX) :
        (mode.wide_track_select ? `FDCML_RECAL_STD_W : `FDCML_RECAL_STD);
    assign write_via_fifo = locked.fifo_enable && !locked.fifo_write_bypass;
    assign read_via_fifo = locked.fifo_enable && !locked.fifo_read_bypass;
    assign dma_request = (locked.fifo_enable && locked.burst_disable) ?
        byte_moved : fifo_request;
    assign scan_match = (scan_host == scan_disk) || (!mode.scan_wildcard_disable &&
        (scan_host == 8'hff || scan_disk == 8'hff));

    // Pin inputs
    logic drive_type, media_change;
    fdcml_sync u_sync_type (.clock(clock), .rst(rst), .pin(drive_type_pin),
        .level(drive_type));
    fdcml_sync u_sync_media (.clock(clock), .rst(rst), .pin(media_change_pin),
        .level(media_change));

    wire fast_rate = rate == fdcml_pkg::fdcml_rate_500 || rate == fdcml_pkg::fdcml_rate_1000;
    wire next_density = mode.density_output == 2'h0 ? 1'b0 :
        mode.density_output == 2'h1 ? 1'b1 :
        mode.density_output == 2'h3 ? (fast_rate == drive_type) : 1'b0;
    wire next_encoded = mode.pump_diagnostic ? pump_n : write_data;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            density_output <= 1'b0;
            encoded_write_output <= 1'b0;
            read_gate <= 1'b0;
            media_changed <= 1'b0;
        end else begin
            density_output <= next_density;
            encoded_write_output <= next_encoded;
            read_gate <= mode.gate_diagnostic && media_change;
            media_changed <= !mode.gate_diagnostic && media_change;
        end
    end

    // Power save timing; 250 and 300 rates double the delay
    localparam int LP_W = 32;
    wire slow_rate = !fast_rate;
    wire [LP_W-1:0] lp_count = slow_rate ? LP_W'(LOWPWR_CYC) << 1 : LP_W'(LOWPWR_CYC);
    wire lp_auto = mode.power_save_select == 2'h1;
    logic lp_busy, lp_done;
    fdcml_timer #(.WIDTH(LP_W)) u_lowpwr (.clock(clock), .rst(rst),
        .load(lp_auto && head_unloaded && !lp_busy && !low_power), .count(lp_count),
        .cancel(!lp_auto || !head_unloaded), .busy(lp_busy), .done(lp_done));
    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            low_power <= 1'b0;
        else if (mode.power_save_select == 2'h0 || soft_reset)
            low_power <= 1'b0;
        else if (mode.power_save_select == 2'h2 || lp_done)
            low_power <= 1'b1;
        else if (lp_auto && !head_unloaded)
            low_power <= 1'b0;
        // Code 3 holds the present state
    end

    // Head settle after implied seek
    fdcml_timer #(.WIDTH(SETTLE_W)) u_settle (.clock(clock), .rst(rst),
        .load(seek_done), .count(settle_cycles(mode.head_settle, rate)),
        .cancel(soft_reset), .busy(settling), .done());

    // Assertions
    property p_invalid;
        @(posedge clock) disable iff (rst)
        take_cmd && !is_lock && !is_version && !is_mode && !soft_reset |=>
            result_byte == 8'h80 && main_status_register[7:6] == 2'h3;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid opcode answer wrong");
    property p_noirq;
        @(posedge clock) disable iff (rst) phase == fdcml_result_invalid |-> !cmd_interrupt;
    endproperty
    a_noirq: assert property (p_noirq) else $error("interrupt on invalid opcode");
    property p_keep;
        @(posedge clock) disable iff (rst) soft_reset && keep_settings |=> $stable(locked);
    endproperty
    a_keep: assert property (p_keep) else $error("locked settings lost");
    property p_unkeep;
        @(posedge clock) disable iff (rst) soft_reset && !keep_settings |=>
            locked.fifo_threshold == 4'h0 && !locked.fifo_enable;
    endproperty
    a_unkeep: assert property (p_unkeep) else $error("soft reset left settings");
    property p_lock_late;
        @(posedge clock) disable iff (rst) take_cmd && is_lock && !soft_reset |=>
            $stable(keep_settings);
    endproperty
    a_lock_late: assert property (p_lock_late) else $error("lock applied early");
    property p_mode_rst;
        @(posedge clock) disable iff (rst) soft_reset |=> mode.head_settle == 4'h8;
    endproperty
    a_mode_rst: assert property (p_mode_rst) else $error("mode not defaulted");
    property p_recal;
        @(posedge clock) disable iff (rst) mode.recal_limit_select && mode.wide_track_select
            |-> recal_limit == 12'd4095;
    endproperty
    a_recal: assert property (p_recal) else $error("recal limit wrong");
    property p_dens;
        @(posedge clock) disable iff (rst) mode.density_output == 2'h1 && !mode_valid
            && !soft_reset ##1 mode.density_output == 2'h1 |-> density_output;
    endproperty
    a_dens: assert property (p_dens) else $error("density not forced high");
    property p_wild;
        @(posedge clock) disable iff (rst) !mode.scan_wildcard_disable && scan_host == 8'hff
            |-> scan_match;
    endproperty
    a_wild: assert property (p_wild) else $error("wildcard missed");
    property p_manual;
        @(posedge clock) disable iff (rst) mode.power_save_select == 2'h2 && !soft_reset
            |=> low_power;
    endproperty
    a_manual: assert property (p_manual) else $error("manual low power late");
    c_lock: cover property (@(posedge clock) disable iff (rst) lock_applies && pending_lock);
    c_invalid: cover property (@(posedge clock) disable iff (rst)
        phase == fdcml_result_invalid && result_read);
    c_version: cover property (@(posedge clock) disable iff (rst)
        phase == fdcml_result_version && result_read);
endmodule

// File: dv/fdcml_host.sv
// Purpose: Host side model issuing command bytes and reading results
// Assumes: Strobes change at the falling edge of clock
// Notes: Lag argument lets the host answer promptly or slowly
`timescale 1ns/1ns
module fdcml_host (
    input wire logic clock,
    input wire logic result_pending,
    input wire logic [7:0] result_byte,
    output logic cmd_valid,
    output logic [7:0] cmd_byte,
    output logic result_read
);
    initial begin
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        result_read = 1'b0;
    end
    task automatic send(input logic [7:0] b);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_byte = b;
        @(negedge clock);
        cmd_valid = 1'b0;
        // Inverted so a stale byte never matches by chance
        cmd_byte = ~b;
    endtask
    // Result read before any further command
    task automatic fetch(input int lag, output logic [7:0] r, output logic ok);
        int n;
        n = 0;
        while (result_pending !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        ok = (n < 20);
        repeat (lag) @(negedge clock);
        r = result_byte;
        result_read = ok;
        @(negedge clock);
        result_read = 1'b0;
    endtask
endmodule

// File: dv/fdcml_mode_lock_command_logic_test.sv
// Purpose: Self-checking bench for mode, lock and version commands
// Assumes: Inputs change at the falling edge
// Notes: Low power delay shortened through LOWPWR_CYC
`timescale 1ns/1ns
module fdcml_mode_lock_command_logic_test;
    localparam logic [7:0] ID = 8'ha5; // Arbitrary value
    localparam logic [3:0] REV = 4'h3;
    localparam int LP = 20;
    // One 2 ms settle unit at 25 MHz
    localparam int SETTLE = 50000;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic soft_reset = 1'b0;
    logic cmd_valid;
    logic [7:0] cmd_byte;
    logic result_read;
    logic [7:0] result_byte;
    logic [7:0] main_status_register;
    logic result_pending;
    logic cmd_interrupt;
    logic config_valid = 1'b0;
    fdcml_pkg::fdcml_locked_s config_in = '0;
    logic mode_valid = 1'b0;
    fdcml_pkg::fdcml_mode_s mode_in = '0;
    fdcml_pkg::fdcml_locked_s locked;
    fdcml_pkg::fdcml_mode_s mode;
    logic keep_settings;
    fdcml_pkg::fdcml_rate_e rate = fdcml_pkg::fdcml_rate_500;
    logic drive_type_pin = 1'b1;
    logic media_change_pin = 1'b1;
    logic head_unloaded = 1'b0;
    logic global_seek_enable = 1'b0;
    logic cmd_seek_bit = 1'b1;
    logic seek_done = 1'b0;
    logic byte_moved = 1'b1;
    logic fifo_request = 1'b0;
    logic settling;
    logic media_changed;
    logic dma_request;
    int waited = 0;
    logic pump_n = 1'b0;
    logic write_data = 1'b1;
    logic [7:0] scan_host = 8'hff;
    logic [7:0] scan_disk = 8'h12;
    logic do_implied_seek;
    logic low_power;
    logic density_output;
    logic read_gate;
    logic encoded_write_output;
    logic scan_match;
    logic write_via_fifo;
    logic read_via_fifo;
    logic wide_track_select;
    logic motor_timer_select;
    logic index_field_omit;
    logic [11:0] recal_limit;
    int err_total = 0;
    int tests_run = 0;
    fdcml_pkg::fdcml_mode_s md;
    fdcml_pkg::fdcml_mode_s mx;
    fdcml_pkg::fdcml_locked_s cf;

    fdcml_core #(.ID_BYTE(ID), .REVISION(REV), .LOWPWR_CYC(LP)) fdcml_core_i (
        .clock, .rst, .soft_reset, .cmd_valid, .cmd_byte, .result_read, .result_byte,
        .main_status_register, .result_pending, .cmd_interrupt, .config_valid,
        .config_in, .mode_valid, .mode_in, .locked, .mode, .keep_settings, .rate,
        .drive_type_pin, .media_change_pin, .head_unloaded, .cmd_seek_bit,
        .global_seek_enable, .seek_done, .pump_n, .write_data, .scan_host,
        .scan_disk, .byte_moved, .fifo_request, .do_implied_seek,
        .settling, .low_power, .density_output, .read_gate, .media_changed,
        .encoded_write_output, .scan_match, .write_via_fifo, .read_via_fifo,
        .dma_request, .wide_track_select, .motor_timer_select, .index_field_omit,
        .recal_limit
    );
    fdcml_host fdcml_host_i (
        .clock, .result_pending, .result_byte, .cmd_valid, .cmd_byte, .result_read
    );

    always #20 clock = ~clock;

    task automatic test_done;
        if (err_total == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ask(input logic [7:0] b);
        fdcml_host_i.send(b);
        chk("status", 8'hd0, main_status_register);
        chk("interrupt", 1'b0, cmd_interrupt);
    endtask
    task automatic rd(input logic [7:0] e, input int lag);
        logic [7:0] r;
        logic ok;
        fdcml_host_i.fetch(lag, r, ok);
        if (ok !== 1'b1) begin
            err_total++;
            test_done();
        end
        chk("result", e, r);
    endtask
    task automatic setm(input fdcml_pkg::fdcml_mode_s mv, input fdcml_pkg::fdcml_locked_s cv);
        mode_in = mv;
        config_in = cv;
        config_valid = 1'b1;
        @(negedge clock);
        config_valid = 1'b0;
        mode_valid = 1'b1;
        @(negedge clock);
        mode_valid = 1'b0;
        // Pins pass a synchroniser, so allow for its delay
        repeat (6) @(negedge clock);
    endtask
    task automatic pulse(input logic hard);
        @(negedge clock);
        if (hard) rst = 1'b1;
        else soft_reset = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        soft_reset = 1'b0;
        @(negedge clock);
    endtask
    task automatic lpw(input int e);
        int n;
        n = 0;
        head_unloaded = 1'b1;
        while (low_power !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        chk("lowpwr delay", 1'b1, n >= e - 2 && n <= e + 4);
        head_unloaded = 1'b0;
        repeat (4) @(negedge clock);
    endtask

    initial begin
        md = '0;
        md.density_output = 2'h3;
        md.head_settle = 4'h8;
        repeat (10) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        chk("mode", md, mode);
        chk("locked", 16'h0000, locked);
        chk("keep", 1'b0, keep_settings);
        chk("status", 8'h80, main_status_register);
        ask(8'h55);
        rd(8'h80, 0);
        ask(8'h95);
        rd(8'h80, 4);
        ask(8'h18);
        rd({ID[7:4], REV}, 1);
        ask(8'h55);
        fdcml_host_i.send(8'h18);
        rd(8'h80, 0);
        chk("pending", 1'b0, result_pending);
        cf = '1;
        cf.precomp_start_track = 8'hc3;
        mx = '1;
        mx.power_save_select = 2'h0;
        mx.density_output = 2'h1;
        mx.head_settle = 4'h3;
        setm(mx, cf);
        ask(8'h94);
        chk("keep", 1'b0, keep_settings);
        rd(8'h10, 3);
        chk("keep", 1'b1, keep_settings);
        pulse(1'b0);
        chk("locked", cf, locked);
        chk("mode", md, mode);
        ask(8'h14);
        rd(8'h00, 0);
        pulse(1'b0);
        chk("locked", 16'h0000, locked);
        ask(8'h94);
        pulse(1'b0);
        chk("keep", 1'b0, keep_settings);
        ask(8'h94);
        rd(8'h10, 0);
        setm(mx, cf);
        pulse(1'b1);
        chk("keep", 1'b0, keep_settings);
        chk("mode", md, mode);
        for (int i = 0; i < 8; i++) begin
            mx = md;
            cf = '0;
            mx.recal_limit_select = i[0];
            mx.motor_timer_select = i[0];
            cf.fifo_write_bypass = i[0];
            mx.wide_track_select = i[1];
            mx.index_field_omit = i[1];
            cf.fifo_read_bypass = i[1];
            cf.fifo_enable = i[2];
            mx.scan_wildcard_disable = i[2];
            mx.gate_diagnostic = i[2];
            mx.pump_diagnostic = i[2];
            mx.implied_seek_honour = i[2];
            cf.burst_disable = i[0];
            cmd_seek_bit = i[0];
            setm(mx, cf);
            chk("recal", i[1] ? (i[0] ? 12'hfff : 12'hf55) : (i[0] ? 12'h0ff : 12'h055),
                recal_limit);
            chk("wide", i[1], wide_track_select);
            chk("motor", i[0], motor_timer_select);
            chk("index", i[1], index_field_omit);
            chk("wfifo", i[2] & ~i[0], write_via_fifo);
            chk("rfifo", i[2] & ~i[1], read_via_fifo);
            chk("scan", !i[2], scan_match);
            chk("gate", i[2], read_gate);
            chk("media", !i[2], media_changed);
            chk("encoded", !i[2], encoded_write_output);
            chk("seek", i[2] & i[0], do_implied_seek);
            chk("dma", i[2] & i[0], dma_request);
        end
        mx = md;
        setm(mx, '0);
        global_seek_enable = 1'b1;
        @(negedge clock);
        chk("seek", 1'b1, do_implied_seek);
        for (int k = 0; k < 2; k++) begin
            mx.density_output = k[1:0];
            setm(mx, '0);
            chk("density", k[0], density_output);
        end
        mx.density_output = 2'h3;
        setm(mx, '0);
        for (int i = 0; i < 8; i++) begin
            drive_type_pin = i[2];
            rate = fdcml_pkg::fdcml_rate_e'(i[1:0]);
            repeat (8) @(negedge clock);
            chk("density", (i[1:0] == 0 || i[1:0] == 3) == i[2], density_output);
        end
        rate = fdcml_pkg::fdcml_rate_500;
        for (int k = 0; k < 4; k++) begin
            mx.power_save_select = k[1] ? 2'h2 : 2'h0;
            if (k[0]) mx.power_save_select = 2'h3;
            setm(mx, '0);
            chk("lowpwr", k[1], low_power);
        end
        mx.power_save_select = 2'h1;
        setm(mx, '0);
        lpw(LP);
        rate = fdcml_pkg::fdcml_rate_250;
        lpw(2 * LP);
        mx.power_save_select = 2'h0;
        mx.head_settle = 4'h1;
        rate = fdcml_pkg::fdcml_rate_1000;
        setm(mx, '0);
        seek_done = 1'b1;
        @(negedge clock);
        seek_done = 1'b0;
        while (settling === 1'b1 && waited < 60000) begin
            @(negedge clock);
            waited++;
        end
        chk("settle", 1'b1, waited >= SETTLE - 2 && waited <= SETTLE + 2);
        test_done();
    end
endmodule
